// ### logic/pmr_bank.sv
// Management register bank of the 10/100 PHY
//
// Summary of operation
// - Reset bit self-clears, reads one while busy
// - Software reset restores all registers to defaults
// - Loopback bit enables internal loop-back
// - Speed bit picks 100 or 10 manually
// - Speed reads negotiated value while negotiating
// - Negotiation enable makes speed, duplex report result
// - Power-down still answers management accesses
// - No spurious MII outputs while powered down
// - Some defaults come from a strap pin
// - Fixed register map at documented offsets
// - Isolate ignores transmit, tri-states receive outputs
// - Restart self-clears, ignored when negotiation off
// - Duplex bit manual, else negotiated duplex
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "pmr_params.svh"
module pmr_bank #(
    // Identifier words; values are arbitrary
    parameter logic [15:0] ID_HIGH = 16'h1234,
    parameter logic [15:0] ID_LOW = 16'h5678
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Strap pin for negotiation enable default
    input wire logic strap_an_i,
    // Status from the PHY core
    input wire logic an_done_i,
    input wire logic an_speed_i,
    input wire logic an_duplex_i,
    input wire logic an_started_i,
    input wire logic link_i,
    input wire logic jabber_i,
    input wire logic pol_rev_i,
    input wire logic [15:0] lp_ability_i,
    input wire logic [4:0] an_exp_i,
    // Controls to the PHY core
    output logic soft_rst_o,
    output logic loopback_o,
    output logic speed100_o,
    output logic duplex_full_o,
    output logic an_enable_o,
    output logic an_restart_o,
    output logic power_down_o,
    output logic isolate_o,
    output logic coll_test_o,
    output logic [15:0] adv_o,
    output logic [15:0] vendor_cfg_o,
    output logic [11:0] vendor_ctl_o,
    output logic [14:0] tenb_cfg_o,
    // MII receive side: core in, pins out
    input wire logic [7:0] core_rx_i,
    output logic [7:0] mii_rx_o,
    output logic mii_rx_oe_o,
    // MII transmit side: pins in, core out
    input wire logic [5:0] mii_tx_i,
    output logic [5:0] core_tx_o
);
    localparam int PMR_RST_CYC = `PMR_SWRST_CYC;
    localparam int PMR_RST_END = PMR_RST_CYC + 1;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    pmr_pkg::pmr_rst_e st_r, st_nxt; // Software reset sequencer
    logic [7:0] cnt_r, cnt_nxt; // Cycles left in software reset
    logic [14:7] ctl_r; // Writable control bits
    pmr_pkg::pmr_word_t adv_r; // Advertisement
    pmr_pkg::pmr_word_t vcfg_r; // Vendor configuration
    logic [11:0] vcs_r; // Writable part of vendor config/status
    logic [15:1] tenb_r; // Writable part of 10BASE-T register
    logic rf_r; // Remote fault, latching high
    logic lnk_r; // Link status, latching low
    logic jab_r; // Jabber, latching high
    logic strap_s; // Synchronised strap level
    logic strap_r; // Strap level held from reset
    logic [5:0] tx_s; // Synchronised transmit pins
    logic rx_pass; // Registered receive pass flag

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire idle = (st_r == pmr_pkg::PMR_IDLE);
    wire sel_ctl = (addr_i == `PMR_OFS_BASIC_MODE_CONTROL);
    wire sel_st = (addr_i == `PMR_OFS_BASIC_MODE_STATUS);
    wire sel_adv = (addr_i == `PMR_OFS_NEGOTIATION_ADVERTISEMENT);
    wire sel_vcfg = (addr_i == `PMR_OFS_VENDOR_CONFIGURATION);
    wire sel_vcs = (addr_i == `PMR_OFS_VENDOR_CONFIG_STATUS);
    wire sel_tenb = (addr_i == `PMR_OFS_TENBASE_CONFIG_STATUS);
    // Writes during a software reset are dropped so defaults stick
    wire wr_ok = wr_i & idle;
    wire wr_ctl = wr_ok & sel_ctl;
    wire sw_start = wr_ctl & wdata_i[`PMR_B_RESET];
    wire rd_st = rd_i & sel_st;
    // Restart only latches when negotiation stays enabled
    wire restart_set = wr_ctl & wdata_i[`PMR_B_AN_RESTART] & wdata_i[`PMR_B_AN_EN];

    ////////////////////////////////////////////////////////////////////////
    // Effective speed and duplex follow negotiation when enabled
    wire an_en = ctl_r[`PMR_B_AN_EN];
    wire eff_speed = an_en ? an_speed_i : ctl_r[`PMR_B_SPEED];
    wire eff_dplx = an_en ? an_duplex_i : ctl_r[`PMR_B_DUPLEX];
    wire [15:0] ctl_rd = {~idle, ctl_r[14], eff_speed, ctl_r[12:9], eff_dplx, ctl_r[7],
                          7'h00};
    // Fixed capability bits read constant regardless of writes
    wire [15:0] st_rd = `PMR_STAT_FIXED
                        | {10'h000, an_done_i, rf_r, 1'b0, lnk_r, jab_r, 1'b0};
    wire [3:0] mode_bits = {eff_speed & eff_dplx, eff_speed & ~eff_dplx,
                            ~eff_speed & eff_dplx, ~eff_speed & ~eff_dplx};

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses read zero
    wire [15:0] rd_mux =
        sel_ctl ? ctl_rd :
        sel_st ? st_rd :
        (addr_i == `PMR_OFS_PHY_IDENTIFIER_HIGH) ? ID_HIGH :
        (addr_i == `PMR_OFS_PHY_IDENTIFIER_LOW) ? ID_LOW :
        sel_adv ? adv_r :
        (addr_i == `PMR_OFS_LINK_PARTNER_ABILITY) ? lp_ability_i :
        (addr_i == `PMR_OFS_NEGOTIATION_EXPANSION) ? {11'h000, an_exp_i} :
        sel_vcfg ? vcfg_r :
        sel_vcs ? {mode_bits, vcs_r} :
        sel_tenb ? {tenb_r, pol_rev_i} :
        16'h0000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software reset sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            pmr_pkg::PMR_IDLE: begin
                if (sw_start) begin
                    st_nxt = pmr_pkg::PMR_BUSY;
                    cnt_nxt = 8'(PMR_RST_CYC - 1);
                end
            end
            pmr_pkg::PMR_BUSY: begin
                // Bit self-clears when the count runs out
                if (cnt_r == 8'h00) begin
                    st_nxt = pmr_pkg::PMR_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: st_nxt = pmr_pkg::PMR_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_r <= pmr_pkg::PMR_IDLE;
            cnt_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap capture: follows the pin during reset, frozen after release
    pmr_sync #(.W(1)) u_strap_sync (
        .clock_i(clock_i),
        .sys_rst_i(1'b0),
        .d_i(strap_an_i),
        .q_o(strap_s)
    );

    // Hold the last strap level seen while reset was high
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            strap_r <= strap_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; restart bit clears once negotiation starts
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ctl_r <= 8'(`PMR_CTL_RST >> 7);
            ctl_r[`PMR_B_AN_EN] <= strap_s;
        end else if (sw_start) begin
            ctl_r <= 8'(`PMR_CTL_RST >> 7);
            ctl_r[`PMR_B_AN_EN] <= strap_r;
        end else if (wr_ctl) begin
            ctl_r[14:10] <= wdata_i[14:10];
            ctl_r[8:7] <= wdata_i[8:7];
            // Set beats the core's start acknowledge
            ctl_r[`PMR_B_AN_RESTART] <= restart_set
                | (ctl_r[`PMR_B_AN_RESTART] & ~an_started_i);
        end else if (an_started_i) begin
            ctl_r[`PMR_B_AN_RESTART] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read/write configuration registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || sw_start) begin
            adv_r <= `PMR_ADV_RST;
            vcfg_r <= `PMR_VCFG_RST;
            vcs_r <= 12'(`PMR_VCS_RST);
            tenb_r <= 15'(`PMR_TENB_RST >> 1);
        end else begin
            if (wr_ok && sel_adv) begin
                adv_r <= wdata_i;
            end
            if (wr_ok && sel_vcfg) begin
                vcfg_r <= wdata_i;
            end
            // Mode bits are status; writes to them are dropped
            if (wr_ok && sel_vcs) begin
                vcs_r <= wdata_i[11:0];
            end
            if (wr_ok && sel_tenb) begin
                tenb_r <= wdata_i[15:1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched status bits: a new event beats the clear on read
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || sw_start) begin
            rf_r <= 1'b0;
            jab_r <= 1'b0;
            lnk_r <= 1'b0;
        end else begin
            rf_r <= lp_ability_i[`PMR_B_LP_RF] | (rf_r & ~rd_st);
            jab_r <= jabber_i | (jab_r & ~rd_st);
            // A drop is held low until read, then tracks the line
            lnk_r <= link_i & (lnk_r | rd_st);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // MII gating: quiet in power-down, released pins when isolated
    wire rx_allow = ~ctl_r[`PMR_B_ISOLATE] & ~ctl_r[`PMR_B_PDOWN];

    pmr_gate #(.W(8)) u_rx_gate (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pass_i(rx_allow),
        .d_i(core_rx_i),
        .q_o(mii_rx_o),
        .pass_o(rx_pass)
    );

    // Transmit pins come from outside the clock domain
    pmr_sync #(.W(6)) u_tx_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .d_i(mii_tx_i),
        .q_o(tx_s)
    );

    // Isolated or sleeping PHY ignores transmit inputs
    pmr_gate #(.W(6)) u_tx_gate (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pass_i(rx_allow),
        .d_i(tx_s),
        .q_o(core_tx_o),
        .pass_o()
    );

    // Pins stay driven (low) in power-down; only isolate releases them
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mii_rx_oe_o <= 1'b0;
        end else begin
            mii_rx_oe_o <= ~ctl_r[`PMR_B_ISOLATE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the core
    assign soft_rst_o = ~idle;
    assign loopback_o = ctl_r[`PMR_B_LOOPBACK];
    assign speed100_o = eff_speed;
    assign duplex_full_o = eff_dplx;
    assign an_enable_o = an_en;
    assign an_restart_o = ctl_r[`PMR_B_AN_RESTART];
    assign power_down_o = ctl_r[`PMR_B_PDOWN];
    assign isolate_o = ctl_r[`PMR_B_ISOLATE];
    assign coll_test_o = ctl_r[`PMR_B_COLL];
    assign adv_o = adv_r;
    assign vendor_cfg_o = vcfg_r;
    assign vendor_ctl_o = vcs_r;
    assign tenb_cfg_o = tenb_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    AST_SWRST_BUSY: assert property (sw_start |=> soft_rst_o [*8])
        else $error("soft reset not held after start");
    AST_SWRST_END: assert property (sw_start |-> ##PMR_RST_END !soft_rst_o)
        else $error("soft reset did not self-clear in time");
    AST_SWRST_READ: assert property (rd_i && sel_ctl && !idle |=> rdata_o[15])
        else $error("reset bit read zero while busy");
    AST_SWRST_DEF: assert property (sw_start |=> !loopback_o && !power_down_o
        && !isolate_o && adv_o == `PMR_ADV_RST && an_enable_o == $past(strap_r))
        else $error("soft reset left a non-default value");
    AST_LOOPBACK: assert property (wr_ctl && !sw_start
        |=> loopback_o == $past(wdata_i[`PMR_B_LOOPBACK]))
        else $error("loopback bit not taken");
    AST_SPEED_RD: assert property (rd_i && sel_ctl
        |=> rdata_o[13] == ($past(an_en) ? $past(an_speed_i) : $past(ctl_r[13])))
        else $error("speed readback wrong");
    AST_DUPLEX_RD: assert property (rd_i && sel_ctl
        |=> rdata_o[8] == ($past(an_en) ? $past(an_duplex_i) : $past(ctl_r[8])))
        else $error("duplex readback wrong");
    AST_PDOWN_ANS: assert property (power_down_o && rd_i && sel_st
        |=> rdata_o[15:11] == 5'h0F)
        else $error("no answer in power-down");
    AST_PDOWN_QUIET: assert property (power_down_o |=> mii_rx_o == 8'h00)
        else $error("MII outputs active in power-down");
    AST_ISO_OFF: assert property (isolate_o |=> !mii_rx_oe_o && !rx_pass)
        else $error("isolated PHY still drives MII");
    AST_RESTART_OFF: assert property (wr_ctl && !wdata_i[`PMR_B_AN_EN]
        |=> !an_restart_o)
        else $error("restart latched with negotiation off");
    AST_UNMAPPED: assert property (rd_i && addr_i == 5'h08 |=> rdata_o == 16'h0000)
        else $error("unmapped address read nonzero");

    COV_SWRST: cover property (sw_start ##1 soft_rst_o ##PMR_RST_CYC !soft_rst_o);
    COV_RF_LATCH: cover property (rf_r && rd_st ##1 rdata_o[`PMR_B_RFAULT]);
    COV_RESTART: cover property (restart_set ##[1:20] !an_restart_o);
    COV_ISOLATE: cover property (wr_ctl && wdata_i[`PMR_B_ISOLATE] ##2 !mii_rx_oe_o);
endmodule

// ### pkg/pmr_params.svh
// Offsets, bit positions, reset values and timing counts of the PHY management bank
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH
// Register offsets
`define PMR_OFS_BASIC_MODE_CONTROL 5'h00
`define PMR_OFS_BASIC_MODE_STATUS 5'h01
`define PMR_OFS_PHY_IDENTIFIER_HIGH 5'h02
`define PMR_OFS_PHY_IDENTIFIER_LOW 5'h03
`define PMR_OFS_NEGOTIATION_ADVERTISEMENT 5'h04
`define PMR_OFS_LINK_PARTNER_ABILITY 5'h05
`define PMR_OFS_NEGOTIATION_EXPANSION 5'h06
`define PMR_OFS_VENDOR_CONFIGURATION 5'h10
`define PMR_OFS_VENDOR_CONFIG_STATUS 5'h11
`define PMR_OFS_TENBASE_CONFIG_STATUS 5'h12
// Control register bit positions
`define PMR_B_RESET 15
`define PMR_B_LOOPBACK 14
`define PMR_B_SPEED 13
`define PMR_B_AN_EN 12
`define PMR_B_PDOWN 11
`define PMR_B_ISOLATE 10
`define PMR_B_AN_RESTART 9
`define PMR_B_DUPLEX 8
`define PMR_B_COLL 7
// Status register bit positions of live fields
`define PMR_B_AN_DONE 5
`define PMR_B_RFAULT 4
`define PMR_B_LINK 2
`define PMR_B_JABBER 1
// Partner ability remote-fault bit
`define PMR_B_LP_RF 13
// Reset values
`define PMR_CTL_RST 16'h3100
`define PMR_STAT_FIXED 16'h7809
`define PMR_ADV_RST 16'h01E1
`define PMR_VCFG_RST 16'h0000
`define PMR_VCS_RST 16'h0000
`define PMR_TENB_RST 16'h7800
// Timing: software reset duration
`define PMR_CLK_NS 4
`define PMR_SWRST_NS 400
`define PMR_SWRST_CYC ((`PMR_SWRST_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)
`endif

// ### pkg/pmr_pkg.sv
// Types shared by the PHY management bank
package pmr_pkg;
    // Software reset sequencer states
    typedef enum logic {PMR_IDLE, PMR_BUSY} pmr_rst_e;
    // One management register word
    typedef logic [15:0] pmr_word_t;
endpackage

// ### logic/pmr_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pmr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First stage feeds only the second stage
    logic [W-1:0] meta_r;

    // Both stages clear under reset
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ### logic/pmr_gate.sv
// Registered gate that forces a bus to zero while blocked
`timescale 1ns/1ns
module pmr_gate #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Pass control and data
    input wire logic pass_i,
    input wire logic [W-1:0] d_i,
    // Gated data and its registered pass flag
    output logic [W-1:0] q_o,
    output logic pass_o
);
    // Registered so a blocked bus never glitches on the pins
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            q_o <= '0;
            pass_o <= 1'b0;
        end else begin
            q_o <= pass_i ? d_i : '0;
            pass_o <= pass_i;
        end
    end
endmodule

// ### verification/pmr_core_model.sv
// Behavioural model of the PHY core that sits behind the management bank
`timescale 1ns/1ns
module pmr_core_model #(
    parameter int START_DLY = 8
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Controls from the bank
    input wire logic soft_rst_i,
    input wire logic an_restart_i,
    input wire logic [15:0] adv_i,
    // Negotiation status to the bank
    output logic an_done_o,
    output logic an_speed_o,
    output logic an_duplex_o,
    output logic an_started_o,
    // Line status to the bank
    output logic link_o,
    output logic jabber_o,
    output logic pol_rev_o,
    output logic [15:0] lp_ability_o,
    output logic [4:0] an_exp_o,
    // Receive data towards the MII
    output logic [7:0] core_rx_o
);
    // Cycles spent waiting before negotiation starts
    logic [7:0] wait_r;

    // Quiet line: link up, no jabber, no remote fault
    assign link_o = 1'b1;
    assign jabber_o = 1'b0;
    assign pol_rev_o = 1'b0;
    assign lp_ability_o = 16'h45E1;
    assign an_exp_o = 5'h01;

    ////////////////////////////////////////////////////////////////
    // Negotiation engine; a slow start keeps the restart bit visible
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || soft_rst_i) begin
            // Any reset renegotiates from the advertised abilities
            wait_r <= 8'h00;
            an_started_o <= 1'b0;
            an_done_o <= 1'b1;
            an_speed_o <= adv_i[8] | adv_i[7];
            an_duplex_o <= adv_i[8] | adv_i[6];
            core_rx_o <= 8'h00;
        end else begin
            // Counting receive pattern so a stale byte is visible
            core_rx_o <= core_rx_o + 8'h01;
            an_started_o <= 1'b0;
            if (an_restart_i && !an_started_o) begin
                an_done_o <= 1'b0;
                wait_r <= wait_r + 8'h01;
                if (wait_r == START_DLY[7:0]) begin
                    // Start acknowledged, result taken from advertisement
                    an_started_o <= 1'b1;
                    an_done_o <= 1'b1;
                    wait_r <= 8'h00;
                    an_speed_o <= adv_i[8] | adv_i[7];
                    an_duplex_o <= adv_i[8] | adv_i[6];
                end
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the PHY management register bank
`timescale 1ns/1ns
module testbench;
    // Clock, reset and strap
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic strap_an_i = 1'b1;
    // Register port
    logic [4:0] addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o, lp_ability_i, adv_o, vendor_cfg_o;
    // Core side and MII
    logic an_done_i, an_speed_i, an_duplex_i, an_started_i, link_i, jabber_i, pol_rev_i;
    logic soft_rst_o, loopback_o, speed100_o, duplex_full_o, an_enable_o, an_restart_o;
    logic power_down_o, isolate_o, coll_test_o, mii_rx_oe_o;
    logic [4:0] an_exp_i;
    logic [11:0] vendor_ctl_o;
    logic [14:0] tenb_cfg_o;
    logic [7:0] core_rx_i, mii_rx_o;
    logic [5:0] mii_tx_i = 6'h2A;
    logic [5:0] core_tx_o;
    // Score and software reset length
    int mismatches = 0;
    int comparisons = 0;
    int rst_len = 0;
    // One table row: optional write, then a read of the same address
    typedef struct {logic wr; logic [4:0] a; logic [15:0] d; logic [15:0] e;} pmr_row_s;
    pmr_row_s rows [18] = '{
        '{1'b0, 5'h00, 16'h0000, 16'h3100}, '{1'b0, 5'h01, 16'h0000, 16'h7829},
        '{1'b0, 5'h02, 16'h0000, 16'h1234}, '{1'b0, 5'h03, 16'h0000, 16'h5678},
        '{1'b0, 5'h04, 16'h0000, 16'h01E1}, '{1'b0, 5'h05, 16'h0000, 16'h45E1},
        '{1'b0, 5'h06, 16'h0000, 16'h0001}, '{1'b0, 5'h10, 16'h0000, 16'h0000},
        '{1'b0, 5'h11, 16'h0000, 16'h8000}, '{1'b0, 5'h12, 16'h0000, 16'h7800},
        '{1'b1, 5'h04, 16'hABCD, 16'hABCD}, '{1'b1, 5'h10, 16'h5A5A, 16'h5A5A},
        '{1'b1, 5'h11, 16'h0FFF, 16'h8FFF}, '{1'b1, 5'h12, 16'hFFFF, 16'hFFFE},
        '{1'b1, 5'h01, 16'h0000, 16'h782D}, '{1'b1, 5'h02, 16'h0000, 16'h1234},
        '{1'b1, 5'h08, 16'hFFFF, 16'h0000}, '{1'b1, 5'h1F, 16'hFFFF, 16'h0000}};

    ////////////////////////////////////////////////////////////////
    // Design and its core model
    pmr_bank pmr_bank_inst (.*);
    pmr_core_model pmr_core_model_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .soft_rst_i(soft_rst_o), .an_restart_i(an_restart_o), .adv_i(adv_o),
        .an_done_o(an_done_i), .an_speed_o(an_speed_i), .an_duplex_o(an_duplex_i),
        .an_started_o(an_started_i), .link_o(link_i), .jabber_o(jabber_i),
        .pol_rev_o(pol_rev_i), .lp_ability_o(lp_ability_i), .an_exp_o(an_exp_i),
        .core_rx_o(core_rx_i));

    // 250 MHz clock
    initial begin
        forever #2 clock_i = ~clock_i;
    end

    // Length of the software reset in cycles
    always @(posedge clock_i) begin
        if (soft_rst_o === 1'b1) begin
            rst_len++;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read strobe; data is taken in the following cycle only
    task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Bounded wait for soft reset (1) or restart (0) to drop
    task automatic wait_idle(input bit rst_sel);
        int n;
        n = 0;
        while ((rst_sel ? soft_rst_o : an_restart_o) !== 1'b0 && n < 300) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 300) begin
            mismatches++;
            $display("mismatch wait_idle expected 0 seen 1");
            wrap_up();
        end
        #1;
    endtask

    // Verdict and end of run
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] v;
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        // Map, defaults, read-only and unmapped places
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                reg_wr(rows[i].a, rows[i].d);
            end
            reg_rd(rows[i].a, v);
            check($sformatf("reg_%h", rows[i].a), v, rows[i].e);
        end
        // Written values reach the core-side outputs
        check("adv_o", adv_o, 16'hABCD);
        check("vendor_cfg_o", vendor_cfg_o, 16'h5A5A);
        check("vendor_ctl_o", 16'(vendor_ctl_o), 16'h0FFF);
        check("tenb_cfg_o", 16'(tenb_cfg_o), 16'h7FFF);
        // Restart with 10 half advertised; bit reads one until started
        reg_wr(5'h04, 16'h0021);
        reg_wr(5'h00, 16'h1200);
        reg_rd(5'h00, v);
        check("ctl_restart", v, 16'h3300);
        wait_idle(1'b0);
        reg_rd(5'h00, v);
        check("ctl_negotiated", v, 16'h1000);
        check("speed100", speed100_o, 16'h0000);
        check("duplex_full", duplex_full_o, 16'h0000);
        // Restart has no effect with negotiation off
        reg_wr(5'h00, 16'h0200);
        reg_rd(5'h00, v);
        check("ctl_restart_off", v, 16'h0000);
        check("an_restart", an_restart_o, 16'h0000);
        // Manual speed and duplex
        reg_wr(5'h00, 16'h2100);
        reg_rd(5'h11, v);
        check("mode_100f", v, 16'h8FFF);
        check("speed100_man", speed100_o, 16'h0001);
        reg_wr(5'h00, 16'h0000);
        reg_rd(5'h11, v);
        check("mode_10h", v, 16'h1FFF);
        check("duplex_man", duplex_full_o, 16'h0000);
        // Loopback; traffic after it may stay dead for a long while
        reg_wr(5'h00, 16'h4000);
        reg_rd(5'h00, v);
        check("ctl_loop", v, 16'h4000);
        check("loopback", loopback_o, 16'h0001);
        // Power-down with collision test: still served, outputs quiet
        reg_wr(5'h00, 16'h0880);
        reg_rd(5'h00, v);
        check("ctl_pdown", v, 16'h0880);
        check("coll_test", coll_test_o, 16'h0001);
        check("rx_pdown", mii_rx_o, 16'h0000);
        check("oe_pdown", mii_rx_oe_o, 16'h0001);
        check("power_down", power_down_o, 16'h0001);
        reg_rd(5'h01, v);
        check("st_pdown", v, 16'h782D);
        repeat (2) @(posedge clock_i);
        #1 check("tx_pdown", core_tx_o, 16'h0000);
        // Isolate: pins released, transmit ignored, port still served
        reg_wr(5'h00, 16'h0400);
        reg_rd(5'h00, v);
        check("ctl_iso", v, 16'h0400);
        check("oe_iso", mii_rx_oe_o, 16'h0000);
        check("isolate", isolate_o, 16'h0001);
        repeat (3) @(posedge clock_i);
        #1 check("tx_iso", core_tx_o, 16'h0000);
        // Back to normal: both MII paths flow again
        reg_wr(5'h00, 16'h0000);
        repeat (4) @(posedge clock_i);
        #1 check("tx_norm", core_tx_o, 16'h002A);
        check("rx_norm", mii_rx_o, 8'(core_rx_i - 8'h01));
        check("oe_norm", mii_rx_oe_o, 16'h0001);
        // Software reset: reads one while busy, writes ignored
        rst_len = 0;
        reg_wr(5'h00, 16'h8000);
        reg_wr(5'h04, 16'h1111);
        reg_rd(5'h00, v);
        check("ctl_busy", v[15], 16'h0001);
        wait_idle(1'b1);
        check("rst_len", 16'(rst_len), 16'(`PMR_SWRST_CYC));
        reg_rd(5'h00, v);
        check("ctl_after", v, 16'h3100);
        reg_rd(5'h04, v);
        check("adv_after", v, 16'h01E1);
        reg_rd(5'h10, v);
        check("vcfg_after", v, 16'h0000);
        reg_rd(5'h12, v);
        check("tenb_after", v, 16'h7800);
        // Strap low at reset: negotiation off by default
        @(posedge clock_i);
        strap_an_i <= 1'b0;
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        reg_rd(5'h00, v);
        check("ctl_strap", v, 16'h2100);
        check("an_enable", an_enable_o, 16'h0000);
        wrap_up();
    end
endmodule
